// [level_alarm_pkg.sv]
// shared constants for the level alarm, relay and fill timeout block
// assumes a 100 MHz system clock and 32-bit AHB-Lite register access
package level_alarm_pkg;
	localparam int          NUM_ALARMS      = 4;
	localparam int          NUM_RELAYS      = 4;
	localparam int          NUM_CHANNELS    = 2;
	localparam int          LEVEL_W         = 16;
	localparam int          CLK_HZ          = 100000000;
	localparam int          MINUTE_S        = 60;
	localparam int          TICK_MS         = 1;
	localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int          MS_PER_MINUTE   = MINUTE_S * 1000;

	// register byte offsets
	localparam logic [7:0]  ADDR_ALARM_CFG  = 8'h00;
	localparam logic [7:0]  ADDR_RELAY_CFG  = 8'h04;
	localparam logic [7:0]  ADDR_ALARM_SP01 = 8'h08;
	localparam logic [7:0]  ADDR_ALARM_SP23 = 8'h0C;
	localparam logic [7:0]  ADDR_RELAY_SP01 = 8'h10;
	localparam logic [7:0]  ADDR_RELAY_SP23 = 8'h14;
	localparam logic [7:0]  ADDR_FILL_CFG   = 8'h18;
	localparam logic [7:0]  ADDR_CONTROL    = 8'h1C;
	localparam logic [7:0]  ADDR_STATUS     = 8'h20;
	localparam logic [7:0]  ADDR_LEVELS     = 8'h24;

	// per-unit config field: bits [1:0] source, bit 2 direction, 4 bits per unit
	localparam int          CFG_STRIDE      = 4;
	localparam int          CFG_DIR_BIT     = 2;
	localparam logic [1:0]  SRC_NONE        = 2'h0;
	localparam logic [1:0]  SRC_FIRST       = 2'h1;
	localparam logic [1:0]  SRC_SECOND      = 2'h2;

	// fill config: timeout minutes, 8 bits per channel
	localparam int          FILL_MIN_W      = 8;
	localparam logic [31:0] FILL_CFG_RST    = 32'h0000_0000;
	localparam logic [31:0] CFG_RST         = 32'h0000_0000;
	localparam logic [31:0] SP_RST          = 32'h0000_0000;

	// control register bits
	localparam int          CTRL_MUTE_BIT   = 0;
	localparam int          CTRL_TO_CLR_LO  = 1;
endpackage : level_alarm_pkg

// [level_alarm_relay_timeout.sv]
// level alarms, relays and per-channel fill timeout with AHB-Lite registers
// assumes level samples arrive with a one-cycle valid strobe, synchronous inputs
// Overview of operation
// RULE_01: four alarms, each from either channel
// RULE_02: alarm source none never activates
// RULE_03: alarm direction below-equal or above-equal
// RULE_04: any alarm sounds annunciator, lights panel
// RULE_05: alarms follow comparison, no latching
// RULE_06: mute silences annunciator, alarms stay
// RULE_07: any alarm change clears the mute
// RULE_08: simultaneous alarms, status summary kept
// RULE_09: footer indicator red while alarm active
// RULE_10: four relays, own setpoints, alarm-independent
// RULE_11: normally open, closed while comparison true
// RULE_12: relay source none stays open
// RULE_13: relay direction below-equal or above-equal
// RULE_14: fill timeout alarm per channel
// RULE_15: fill start runs timer, timeout if unreached
// RULE_16: timeout de-energizes that channel valve
// RULE_17: timeout sounds annunciator, sets footer flag
// RULE_18: zero minute interval disables timeout
// RULE_19: two independent fill controllers
// RULE_20: timeout stops the active fill cycle
// RULE_21: comparisons refreshed on every sample
`timescale 1ns/1ps
module level_alarm_relay_timeout
#(
	// fill timer tick length in clocks; shortened only so a timeout fits a simulation
	parameter int TICK_CYCLES = level_alarm_pkg::TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// level channels
	input  wire logic        sample_valid_i,
	input  wire logic [15:0] level_first_i,
	input  wire logic [15:0] level_second_i,
	// fill controller
	input  wire logic [1:0]  fill_start_i,
	input  wire logic [1:0]  fill_stop_reached_i,
	input  wire logic [1:0]  fill_valve_req_i,
	input  wire logic        mute_request_button_i,
	// annunciator, indicators, relays, valves
	output logic             annunciator_o,
	output logic             panel_alarm_o,
	output logic             footer_alarm_red_o,
	output logic      [3:0]  alarm_active_o,
	output logic      [3:0]  relay_closed_o,
	output logic      [1:0]  timeout_footer_flag_o,
	output logic      [1:0]  fill_valve_o
);
	typedef struct packed {
		logic [31:0] alarm_cfg;
		logic [31:0] relay_cfg;
		logic [63:0] alarm_sp;
		logic [63:0] relay_sp;
		logic [31:0] fill_cfg;
		logic [15:0] lvl1;
		logic [15:0] lvl2;
		logic [3:0]  alarm;
		logic [3:0]  relay;
		logic        muted;
		logic [1:0]  timing;
		logic [1:0]  timeout;
		logic [1:0]  valve;
		logic [16:0] tick_cnt;
		logic [15:0] ms_cnt0;
		logic [15:0] ms_cnt1;
		logic [7:0]  min_cnt0;
		logic [7:0]  min_cnt1;
		logic        ph_valid;
		logic        ph_write;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
		logic        annunc;
		logic        panel;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
	localparam logic [15:0] MS_LAST   = 16'(level_alarm_pkg::MS_PER_MINUTE - 1);

	logic [3:0]  alarm_cmp;
	logic [3:0]  relay_cmp;
	logic        tick;

	assign tick = (st_r.tick_cnt == TICK_LAST);

	// unit comparators, one generate per alarm and relay
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_cmp
			logic [1:0]  a_src;
			logic        a_dir;
			logic [15:0] a_sp;
			logic [15:0] a_lvl;
			logic [1:0]  r_src;
			logic        r_dir;
			logic [15:0] r_sp;
			logic [15:0] r_lvl;
			assign a_src = st_r.alarm_cfg[gi*level_alarm_pkg::CFG_STRIDE +: 2];
			assign a_dir = st_r.alarm_cfg[gi*level_alarm_pkg::CFG_STRIDE + level_alarm_pkg::CFG_DIR_BIT];
			assign a_sp  = st_r.alarm_sp[gi*16 +: 16];
			// RULE_01 channel select
			assign a_lvl = (a_src == level_alarm_pkg::SRC_SECOND) ? st_r.lvl2 : st_r.lvl1;
			// RULE_02 RULE_03 source and direction
			assign alarm_cmp[gi] = (a_src == level_alarm_pkg::SRC_FIRST || a_src == level_alarm_pkg::SRC_SECOND)
				&& (a_dir ? (a_lvl >= a_sp) : (a_lvl <= a_sp));
			assign r_src = st_r.relay_cfg[gi*level_alarm_pkg::CFG_STRIDE +: 2];
			assign r_dir = st_r.relay_cfg[gi*level_alarm_pkg::CFG_STRIDE + level_alarm_pkg::CFG_DIR_BIT];
			assign r_sp  = st_r.relay_sp[gi*16 +: 16];
			assign r_lvl = (r_src == level_alarm_pkg::SRC_SECOND) ? st_r.lvl2 : st_r.lvl1;
			// RULE_12 RULE_13 relay compare
			assign relay_cmp[gi] = (r_src == level_alarm_pkg::SRC_FIRST || r_src == level_alarm_pkg::SRC_SECOND)
				&& (r_dir ? (r_lvl >= r_sp) : (r_lvl <= r_sp));
		end
	endgenerate

	always_comb
	begin
		logic [7:0]  lim;
		logic [31:0] rd;
		logic        to_set;
		lim    = 8'h00;
		rd     = 32'h0000_0000;
		to_set = 1'b0;
		st_nxt = st_r;

		// bus data phase
		if (st_r.ph_valid && st_r.ph_write)
		begin
			case (st_r.ph_addr)
				level_alarm_pkg::ADDR_ALARM_CFG:  st_nxt.alarm_cfg        = hwdata_i;
				level_alarm_pkg::ADDR_RELAY_CFG:  st_nxt.relay_cfg        = hwdata_i;
				level_alarm_pkg::ADDR_ALARM_SP01: st_nxt.alarm_sp[31:0]   = hwdata_i;
				level_alarm_pkg::ADDR_ALARM_SP23: st_nxt.alarm_sp[63:32]  = hwdata_i;
				level_alarm_pkg::ADDR_RELAY_SP01: st_nxt.relay_sp[31:0]   = hwdata_i;
				level_alarm_pkg::ADDR_RELAY_SP23: st_nxt.relay_sp[63:32]  = hwdata_i;
				level_alarm_pkg::ADDR_FILL_CFG:   st_nxt.fill_cfg         = hwdata_i;
				default:                          st_nxt.fill_cfg         = st_nxt.fill_cfg;
			endcase
		end

		// address phase capture
		st_nxt.ph_valid = hsel_i && hready_i && htrans_i[1];
		st_nxt.ph_write = hwrite_i;
		st_nxt.ph_addr  = haddr_i[7:0];
		case (haddr_i[7:0])
			level_alarm_pkg::ADDR_ALARM_CFG:  rd = st_r.alarm_cfg;
			level_alarm_pkg::ADDR_RELAY_CFG:  rd = st_r.relay_cfg;
			level_alarm_pkg::ADDR_ALARM_SP01: rd = st_r.alarm_sp[31:0];
			level_alarm_pkg::ADDR_ALARM_SP23: rd = st_r.alarm_sp[63:32];
			level_alarm_pkg::ADDR_RELAY_SP01: rd = st_r.relay_sp[31:0];
			level_alarm_pkg::ADDR_RELAY_SP23: rd = st_r.relay_sp[63:32];
			level_alarm_pkg::ADDR_FILL_CFG:   rd = st_r.fill_cfg;
			// RULE_08 status summary
			level_alarm_pkg::ADDR_STATUS:     rd = {16'h0000, st_r.valve, st_r.timeout, st_r.timing,
				st_r.muted, st_r.annunc, st_r.relay, st_r.alarm};
			level_alarm_pkg::ADDR_LEVELS:     rd = {st_r.lvl2, st_r.lvl1};
			default:                          rd = 32'h0000_0000;
		endcase
		st_nxt.rdata = (hsel_i && hready_i && htrans_i[1] && !hwrite_i) ? rd : 32'h0000_0000;

		// RULE_21 sample refresh
		if (sample_valid_i)
		begin
			st_nxt.lvl1 = level_first_i;
			st_nxt.lvl2 = level_second_i;
		end
		// RULE_05 RULE_08 non-latching alarms
		st_nxt.alarm = alarm_cmp;
		// RULE_10 RULE_11 relays
		st_nxt.relay = relay_cmp;

		// RULE_06 RULE_07 mute handling, a change wins over a mute
		if (st_r.alarm != alarm_cmp)
			st_nxt.muted = 1'b0;
		else if ((mute_request_button_i ||
			(st_r.ph_valid && st_r.ph_write && st_r.ph_addr == level_alarm_pkg::ADDR_CONTROL &&
			hwdata_i[level_alarm_pkg::CTRL_MUTE_BIT])) && (st_r.alarm != 4'h0 || st_r.timeout != 2'h0))
			st_nxt.muted = 1'b1;

		// one ms tick divider
		st_nxt.tick_cnt = tick ? 17'h0_0000 : st_r.tick_cnt + 17'h0_0001;

		// RULE_14 RULE_19 per-channel fill controller
		for (int c = 0; c < 2; c++)
		begin
			lim = st_r.fill_cfg[c*level_alarm_pkg::FILL_MIN_W +: level_alarm_pkg::FILL_MIN_W];
			to_set = 1'b0;
			if (fill_start_i[c] && lim != 8'h00 && !st_r.timeout[c])
				st_nxt.timing[c] = 1'b1;
			// RULE_18 zero disables
			if (lim == 8'h00 || fill_stop_reached_i[c])
				st_nxt.timing[c] = 1'b0;
			if (c == 0)
			begin
				if (fill_start_i[0])
				begin
					st_nxt.ms_cnt0  = 16'h0000;
					st_nxt.min_cnt0 = 8'h00;
				end
				else if (st_r.timing[0] && tick)
				begin
					st_nxt.ms_cnt0 = (st_r.ms_cnt0 == MS_LAST) ? 16'h0000 : st_r.ms_cnt0 + 16'h0001;
					if (st_r.ms_cnt0 == MS_LAST)
						st_nxt.min_cnt0 = st_r.min_cnt0 + 8'h01;
				end
				// RULE_15 elapsed check
				to_set = st_r.timing[0] && lim != 8'h00 && st_r.min_cnt0 >= lim && !fill_stop_reached_i[0];
			end
			else
			begin
				if (fill_start_i[1])
				begin
					st_nxt.ms_cnt1  = 16'h0000;
					st_nxt.min_cnt1 = 8'h00;
				end
				else if (st_r.timing[1] && tick)
				begin
					st_nxt.ms_cnt1 = (st_r.ms_cnt1 == MS_LAST) ? 16'h0000 : st_r.ms_cnt1 + 16'h0001;
					if (st_r.ms_cnt1 == MS_LAST)
						st_nxt.min_cnt1 = st_r.min_cnt1 + 8'h01;
				end
				to_set = st_r.timing[1] && lim != 8'h00 && st_r.min_cnt1 >= lim && !fill_stop_reached_i[1];
			end
			// set wins over software clear
			if (to_set)
			begin
				st_nxt.timeout[c] = 1'b1;
				// RULE_20 stop fill cycle
				st_nxt.timing[c]  = 1'b0;
				st_nxt.muted      = 1'b0;
			end
			else if (st_r.ph_valid && st_r.ph_write && st_r.ph_addr == level_alarm_pkg::ADDR_CONTROL &&
				hwdata_i[level_alarm_pkg::CTRL_TO_CLR_LO + c])
				st_nxt.timeout[c] = 1'b0;
			// RULE_16 valve off during timeout
			st_nxt.valve[c] = fill_valve_req_i[c] && !st_nxt.timeout[c];
		end

		// RULE_04 RULE_17 annunciator
		st_nxt.annunc = (st_nxt.alarm != 4'h0 || st_nxt.timeout != 2'h0) && !st_nxt.muted;
		// RULE_09 footer red
		st_nxt.panel  = (st_nxt.alarm != 4'h0 || st_nxt.timeout != 2'h0);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			st_r           <= '0;
			st_r.alarm_cfg <= level_alarm_pkg::CFG_RST;
			st_r.relay_cfg <= level_alarm_pkg::CFG_RST;
			st_r.fill_cfg  <= level_alarm_pkg::FILL_CFG_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign hrdata_o              = st_r.rdata;
	assign hreadyout_o           = 1'b1;
	assign hresp_o               = 1'b0;
	assign annunciator_o         = st_r.annunc;
	assign panel_alarm_o         = st_r.panel;
	assign footer_alarm_red_o    = st_r.panel;
	assign alarm_active_o        = st_r.alarm;
	assign relay_closed_o        = st_r.relay;
	assign timeout_footer_flag_o = st_r.timeout;
	assign fill_valve_o          = st_r.valve;

	a_alarm_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_05
		alarm_active_o == $past(alarm_cmp) || $past(!rst_n_i))
		else $error("alarm does not follow comparison");
	a_none_silent: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_02
		(st_r.alarm_cfg[1:0] == level_alarm_pkg::SRC_NONE) |=> !alarm_active_o[0] || $past(!rst_n_i))
		else $error("alarm with no source active");
	a_relay_none: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_12
		(st_r.relay_cfg[1:0] == level_alarm_pkg::SRC_NONE && $stable(st_r.relay_cfg)) |=> !relay_closed_o[0])
		else $error("relay with no source closed");
	a_sound_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_04
		(alarm_active_o != 4'h0 && !st_r.muted) |-> annunciator_o)
		else $error("annunciator silent with alarm");
	a_mute_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_06
		st_r.muted |-> !annunciator_o)
		else $error("annunciator while muted");
	a_change_unmute: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_07
		(st_r.alarm != alarm_cmp) |=> !st_r.muted)
		else $error("mute kept after alarm change");
	a_footer_red: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_09
		(alarm_active_o != 4'h0) |-> footer_alarm_red_o)
		else $error("footer not red with alarm");
	a_valve_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_16
		timeout_footer_flag_o[0] |-> !fill_valve_o[0])
		else $error("valve open during timeout");
	a_zero_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_18
		(st_r.fill_cfg[7:0] == 8'h00 && !timeout_footer_flag_o[0]) |=> !timeout_footer_flag_o[0])
		else $error("timeout raised with zero interval");
	a_to_stops: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_20
		$rose(timeout_footer_flag_o[1]) |-> !st_r.timing[1])
		else $error("fill timer runs after timeout");
	a_alarm_below: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_03
		(st_r.alarm_cfg[2:0] == 3'h1) |=> alarm_active_o[0] == $past(st_r.lvl1 <= st_r.alarm_sp[15:0]))
		else $error("alarm below setpoint not followed");
	a_unused_source: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_02
		(st_r.alarm_cfg[13:12] == 2'h3) |=> !alarm_active_o[3])
		else $error("alarm with unused source code active");
	a_relay_above: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_13
		(st_r.relay_cfg[2:0] == 3'h5) |=> relay_closed_o[0] == $past(st_r.lvl1 >= st_r.relay_sp[15:0]))
		else $error("relay above setpoint not followed");
	a_timeout_sound: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_17
		(timeout_footer_flag_o != 2'h0 && !st_r.muted) |-> annunciator_o && footer_alarm_red_o)
		else $error("timeout without annunciator or footer");
	a_valve_off_second: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_16
		timeout_footer_flag_o[1] |-> !fill_valve_o[1])
		else $error("second valve open during timeout");
	a_zero_off_second: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_18
		(st_r.fill_cfg[15:8] == 8'h00 && !timeout_footer_flag_o[1]) |=> !timeout_footer_flag_o[1])
		else $error("second timeout raised with zero interval");
	a_timeout_unmute: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE_07
		$rose(timeout_footer_flag_o[1]) |-> !st_r.muted)
		else $error("mute kept when timeout raised");

	c_alarm_up:   cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(alarm_active_o[0]));
	c_muted:      cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(st_r.muted));
	c_timeout:    cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(timeout_footer_flag_o[0]));
	c_relay_shut: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(relay_closed_o[3]));
endmodule : level_alarm_relay_timeout

// [level_partner.sv]
// model of the two level measurement channels feeding the alarm block
// assumes the bench sets the wanted levels; one sample strobe every four clocks
`timescale 1ns/1ps
module level_partner
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// wanted levels from the bench
	input  wire logic [15:0] want_first_i,
	input  wire logic [15:0] want_second_i,
	// measurement side
	output logic             sample_valid_o,
	output logic      [15:0] level_first_o,
	output logic      [15:0] level_second_o
);
	logic [1:0] div_r;

	// levels only mean something with the strobe; show junk otherwise
	always_ff @(posedge mclk_i)
	begin
		div_r          <= rst_n_i ? div_r + 2'h1 : 2'h0;
		sample_valid_o <= rst_n_i && (div_r == 2'h3);
		level_first_o  <= (rst_n_i && div_r == 2'h3) ? want_first_i : ~want_first_i;
		level_second_o <= (rst_n_i && div_r == 2'h3) ? want_second_i : ~want_second_i;
	end
endmodule : level_partner

// [test_level_alarm_relay_timeout.sv]
// self-checking bench for the level alarm, relay and fill timeout block
// assumes a single-slave AHB-Lite bus and the level_partner model
`timescale 1ns/1ps
module test_level_alarm_relay_timeout;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0]  htrans_i = 2'h0;
	logic        hwrite_i = 1'b0;
	logic [2:0]  hsize_i = 3'h2;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        hresp_o;
	logic        sample_valid_i;
	logic [15:0] level_first_i;
	logic [15:0] level_second_i;
	logic [15:0] want_first = 16'h0;
	logic [15:0] want_second = 16'h0;
	logic [1:0]  fill_start_i = 2'h0;
	logic [1:0]  fill_stop_reached_i = 2'h0;
	logic [1:0]  fill_valve_req_i = 2'h0;
	logic        mute_request_button_i = 1'b0;
	logic        annunciator_o;
	logic        panel_alarm_o;
	logic        footer_alarm_red_o;
	logic [3:0]  alarm_active_o;
	logic [3:0]  relay_closed_o;
	logic [1:0]  timeout_footer_flag_o;
	logic [1:0]  fill_valve_o;
	logic [31:0] rd;
	int          err_count = 0;
	int          samples_checked = 0;

	always #5 mclk_i = ~mclk_i;

	level_partner PARTNER (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .want_first_i(want_first),
		.want_second_i(want_second), .sample_valid_o(sample_valid_i), .level_first_o(level_first_i),
		.level_second_o(level_second_i));

	// one-clock tick so a one-minute fill timeout fits in the run
	level_alarm_relay_timeout #(.TICK_CYCLES(1)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.sample_valid_i(sample_valid_i), .level_first_i(level_first_i), .level_second_i(level_second_i),
		.fill_start_i(fill_start_i), .fill_stop_reached_i(fill_stop_reached_i),
		.fill_valve_req_i(fill_valve_req_i), .mute_request_button_i(mute_request_button_i),
		.annunciator_o(annunciator_o), .panel_alarm_o(panel_alarm_o),
		.footer_alarm_red_o(footer_alarm_red_o), .alarm_active_o(alarm_active_o),
		.relay_closed_o(relay_closed_o), .timeout_footer_flag_o(timeout_footer_flag_o),
		.fill_valve_o(fill_valve_o));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one transfer; hrdata taken at the edge that ends the data phase
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		hsel_i   <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		haddr_i  <= {24'h0, addr};
		@(posedge mclk_i);
		while (hreadyout_o !== 1'b1) @(posedge mclk_i);
		htrans_i <= 2'h0;
		hwdata_i <= wdata;
		@(posedge mclk_i);
		while (hreadyout_o !== 1'b1) @(posedge mclk_i);
		rd = hrdata_o;
		check("response", 32'h0, {31'h0, hresp_o});
	endtask : bus

	task automatic levels(input logic [15:0] a, input logic [15:0] b);
		want_first  <= a;
		want_second <= b;
		repeat (12) @(posedge mclk_i);
	endtask : levels

	task automatic outs(input logic [3:0] al, input logic [3:0] rl, input logic ann, input logic any);
		check("alarms", {28'h0, al}, {28'h0, alarm_active_o});
		check("relays", {28'h0, rl}, {28'h0, relay_closed_o});
		check("annunciator", {31'h0, ann}, {31'h0, annunciator_o});
		check("panel", {31'h0, any}, {31'h0, panel_alarm_o});
		check("footer", {31'h0, any}, {31'h0, footer_alarm_red_o});
	endtask : outs

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	// the one-minute fill timeout dominates: about 60120 cycles
	initial
	begin
		#700000;
		err_count++;
		final_report();
	end

	initial
	begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		levels(16'h0064, 16'h00C8);
		outs(4'h0, 4'h0, 1'b0, 1'b0);
		bus(1'b0, level_alarm_pkg::ADDR_ALARM_CFG, 32'h0);
		check("alarm cfg reset", level_alarm_pkg::CFG_RST, rd);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		bus(1'b0, 8'h40, 32'h0);
		check("unmapped read", 32'h0, rd);
		// alarm units: src first <=, src second >=, none, code 3 >=
		bus(1'b1, level_alarm_pkg::ADDR_ALARM_CFG, 32'h0000_7061);
		bus(1'b1, level_alarm_pkg::ADDR_ALARM_SP01, 32'h00C8_0064);
		bus(1'b1, level_alarm_pkg::ADDR_ALARM_SP23, 32'hFFFF_FFFF);
		bus(1'b1, level_alarm_pkg::ADDR_RELAY_CFG, 32'h0000_1425);
		bus(1'b1, level_alarm_pkg::ADDR_RELAY_SP01, 32'h00C8_0065);
		bus(1'b1, level_alarm_pkg::ADDR_RELAY_SP23, 32'h0032_0000);
		bus(1'b0, level_alarm_pkg::ADDR_RELAY_CFG, 32'h0);
		check("relay cfg", 32'h0000_1425, rd);
		levels(16'h0064, 16'h00CA);
		levels(16'h0064, 16'h00C8);
		outs(4'h3, 4'h2, 1'b1, 1'b1);
		outs(4'h3, 4'h2, 1'b1, 1'b1);
		bus(1'b0, level_alarm_pkg::ADDR_STATUS, 32'h0);
		check("status", 32'h0000_0123, rd);
		mute_request_button_i <= 1'b1;
		@(posedge mclk_i);
		mute_request_button_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		outs(4'h3, 4'h2, 1'b0, 1'b1);
		bus(1'b0, level_alarm_pkg::ADDR_STATUS, 32'h0);
		check("status muted", 32'h0000_0223, rd);
		levels(16'h0065, 16'h00C8);
		outs(4'h2, 4'h3, 1'b1, 1'b1);
		bus(1'b0, level_alarm_pkg::ADDR_STATUS, 32'h0);
		check("status change", 32'h0000_0132, rd);
		levels(16'hEA60, 16'h0064);
		outs(4'h0, 4'h3, 1'b0, 1'b0);
		bus(1'b1, level_alarm_pkg::ADDR_FILL_CFG, 32'h0000_0100);
		fill_valve_req_i <= 2'h3;
		fill_start_i     <= 2'h3;
		@(posedge mclk_i);
		fill_start_i     <= 2'h0;
		repeat (2000) @(posedge mclk_i);
		check("valves", 32'h3, {30'h0, fill_valve_o});
		check("timeout flags", 32'h0, {30'h0, timeout_footer_flag_o});
		fill_valve_req_i <= 2'h1;
		repeat (4) @(posedge mclk_i);
		check("valves", 32'h1, {30'h0, fill_valve_o});
		// second channel times out 60001 edges after its start
		repeat (57990) @(posedge mclk_i);
		check("timeout early", 32'h0, {30'h0, timeout_footer_flag_o});
		fill_valve_req_i <= 2'h3;
		repeat (4) @(posedge mclk_i);
		check("valves before timeout", 32'h3, {30'h0, fill_valve_o});
		repeat (6) @(posedge mclk_i);
		check("timeout flags", 32'h2, {30'h0, timeout_footer_flag_o});
		check("valves", 32'h1, {30'h0, fill_valve_o});
		outs(4'h0, 4'h3, 1'b1, 1'b1);
		bus(1'b0, level_alarm_pkg::ADDR_STATUS, 32'h0);
		check("status timeout", 32'h0000_6130, rd);
		bus(1'b1, level_alarm_pkg::ADDR_CONTROL, 32'h0000_0001);
		bus(1'b0, level_alarm_pkg::ADDR_STATUS, 32'h0);
		check("status timeout muted", 32'h0000_6230, rd);
		bus(1'b1, level_alarm_pkg::ADDR_CONTROL, 32'h0000_0004);
		@(posedge mclk_i);
		check("timeout cleared", 32'h0, {30'h0, timeout_footer_flag_o});
		check("valves restored", 32'h3, {30'h0, fill_valve_o});
		final_report();
	end
endmodule : test_level_alarm_relay_timeout
